// ===== core/jtag_tap_boundary_scan.sv
// Test access port, instruction decode and boundary scan chain
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_boundary_scan
   import jtag_tap_pkg::*;
#(
   parameter int NI = NUM_IN,
   parameter int NO = NUM_OUT,
   parameter int NB = NUM_BIDIR
) (
   // System clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Test access port
   input  wire logic          tck,
   input  wire logic          trst_n,
   input  wire logic          tms,
   input  wire logic          tdi,
   output var  logic          tdo,
   output var  logic          tdo_oe,
   // Device pins
   input  wire logic [NI-1:0] in_pin,
   output var  logic [NO-1:0] out_pin,
   output var  logic [NO-1:0] out_pin_oe,
   input  wire logic [NB-1:0] bd_pin_in,
   output var  logic [NB-1:0] bd_pin_out,
   output var  logic [NB-1:0] bd_pin_oe,
   // System logic side
   input  wire logic [NO-1:0] sys_out,
   input  wire logic [NB-1:0] sys_bd_out,
   input  wire logic [NB-1:0] sys_bd_oe
);

   localparam int LEN     = NI + NO + CELLS_BIDIR * NB;
   localparam int BD_BASE = NI + NO;

   // =====================================================================
   // Controller states
   typedef enum logic [15:0] {
      S_TLR    = 16'h0001,
      S_RTI    = 16'h0002,
      S_SEL_DR = 16'h0004,
      S_CAP_DR = 16'h0008,
      S_SH_DR  = 16'h0010,
      S_EX1_DR = 16'h0020,
      S_PA_DR  = 16'h0040,
      S_EX2_DR = 16'h0080,
      S_UP_DR  = 16'h0100,
      S_SEL_IR = 16'h0200,
      S_CAP_IR = 16'h0400,
      S_SH_IR  = 16'h0800,
      S_EX1_IR = 16'h1000,
      S_PA_IR  = 16'h2000,
      S_EX2_IR = 16'h4000,
      S_UP_IR  = 16'h8000
   } tap_state_t;

   tap_state_t        state;
   tap_state_t        next_state;
   logic [IR_W-1:0]   ir_sh;
   logic [IR_W-1:0]   ir;
   instr_t            kind;
   logic              sel_bsr;
   logic              bypass_bit;
   logic [ID_W-1:0]   id_sh;
   logic [LEN-1:0]    bsr_sh;
   logic [LEN-1:0]    bsr_upd;
   logic [LEN-1:0]    obs;
   logic [LEN-1:0]    obs_sync;
   logic              upd_tgl;
   logic              drive_cells_t;
   logic              highz_t;
   logic [2:0]        ctl_sync;
   logic              tgl_seen;
   logic [LEN-1:0]    upd_copy;

   // =====================================================================
   // Decode and identity helpers
   function automatic instr_t decode(input logic [IR_W-1:0] code);
      case (code)
         IR_EXTEST:   decode = K_EXTEST;
         IR_SAMPLE:   decode = K_SAMPLE;
         IR_IDCODE:   decode = K_IDCODE;
         IR_USERCODE: decode = K_USERCODE;
         IR_CLAMP:    decode = K_CLAMP;
         IR_HIGHZ:    decode = K_HIGHZ;
         default:     decode = K_BYPASS;
      endcase
   endfunction : decode

   function automatic logic [ID_W-1:0] id_word(input logic [3:0]  ver,
                                                input logic [15:0] mid);
      logic [ID_W-1:0] w;
      w = '0;
      w[ID_VER_LSB +: 4]  = ver;
      w[ID_FAM_LSB +: 16] = mid;
      w[ID_MFR_LSB +: 11] = ID_MFR;
      w[0]                = ID_LSB_ONE;
      id_word = w;
   endfunction : id_word
   assign kind    = decode(ir);
   assign sel_bsr = (kind == K_EXTEST) || (kind == K_SAMPLE);

   // =====================================================================
   // Controller, advanced by TMS on rising TCK
   always_comb
   begin
      case (state)
         S_TLR:    next_state = tms ? S_TLR    : S_RTI;
         S_RTI:    next_state = tms ? S_SEL_DR : S_RTI;
         S_SEL_DR: next_state = tms ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: next_state = tms ? S_EX1_DR : S_SH_DR;
         S_SH_DR:  next_state = tms ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: next_state = tms ? S_UP_DR  : S_PA_DR;
         S_PA_DR:  next_state = tms ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: next_state = tms ? S_UP_DR  : S_SH_DR;
         S_UP_DR:  next_state = tms ? S_SEL_DR : S_RTI;
         S_SEL_IR: next_state = tms ? S_TLR    : S_CAP_IR;
         S_CAP_IR: next_state = tms ? S_EX1_IR : S_SH_IR;
         S_SH_IR:  next_state = tms ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: next_state = tms ? S_UP_IR  : S_PA_IR;
         S_PA_IR:  next_state = tms ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: next_state = tms ? S_UP_IR  : S_SH_IR;
         S_UP_IR:  next_state = tms ? S_SEL_DR : S_RTI;
         default:  next_state = S_TLR;
      endcase
   end
   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
         state <= S_TLR;
      else
         state <= next_state;
   end

   // =====================================================================
   // Instruction register
   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
         ir_sh <= IR_CAPTURE;
      else if (state == S_CAP_IR)
         ir_sh <= IR_CAPTURE;
      else if (state == S_SH_IR)
         ir_sh <= {tdi, ir_sh[IR_W-1:1]};
   end
   // Held while shifting; pin mode loads with it, free of decode glitches
   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         ir            <= IR_IDCODE;
         drive_cells_t <= 1'b0;
         highz_t       <= 1'b0;
      end
      else if (state == S_TLR)
      begin
         ir            <= IR_IDCODE;
         drive_cells_t <= 1'b0;
         highz_t       <= 1'b0;
      end
      else if (state == S_UP_IR)
      begin
         ir            <= ir_sh;
         drive_cells_t <= (decode(ir_sh) == K_EXTEST) ||
                          (decode(ir_sh) == K_CLAMP);
         highz_t       <= (decode(ir_sh) == K_HIGHZ);
      end
   end

   // =====================================================================
   // Bypass and identification registers
   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         bypass_bit <= 1'b0;
         id_sh      <= '0;
      end
      else if (state == S_CAP_DR)
      begin
         bypass_bit <= 1'b0;
         id_sh      <= (kind == K_USERCODE) ?
                       id_word(USER_VERSION, ID_PART) :
                       id_word(ID_VERSION, ID_FAMILY);
      end
      else if (state == S_SH_DR)
      begin
         bypass_bit <= tdi;
         id_sh      <= {tdi, id_sh[ID_W-1:1]};
      end
   end

   // =====================================================================
   // Boundary scan chain
   // Observed values in cell order: inputs, outputs, then in/out/ctl
   always_comb
   begin
      obs = '0;
      obs[NI-1:0]     = in_pin;
      obs[NI +: NO]   = sys_out;
      for (int i = 0; i < NB; i++)
      begin
         obs[BD_BASE + CELLS_BIDIR*i]     = bd_pin_in[i];
         obs[BD_BASE + CELLS_BIDIR*i + 1] = sys_bd_out[i];
         obs[BD_BASE + CELLS_BIDIR*i + 2] = sys_bd_oe[i];
      end
   end

   // Pins are asynchronous to TCK, so they pass two stages first
   bit_sync #(.WIDTH (LEN)) u_obs_sync (
      .clk   (tck),
      .rst_n (trst_n),
      .d     (obs),
      .q     (obs_sync)
   );

   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
         bsr_sh <= '0;
      else if (state == S_CAP_DR && sel_bsr)
         bsr_sh <= obs_sync;
      else if (state == S_SH_DR && sel_bsr)
         bsr_sh <= {tdi, bsr_sh[LEN-1:1]};
   end
   // Update stage holds cells steady while the chain shifts
   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         bsr_upd <= '0;
         upd_tgl <= 1'b0;
      end
      else if (state == S_UP_DR && sel_bsr)
      begin
         bsr_upd <= bsr_sh;
         upd_tgl <= ~upd_tgl;
      end
   end

   // =====================================================================
   // Serial output on falling TCK, enabled only while shifting
   always_ff @(negedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else
      begin
         tdo_oe <= (state == S_SH_DR) || (state == S_SH_IR);
         if (state == S_SH_IR)
            tdo <= ir_sh[0];
         else if (sel_bsr)
            tdo <= bsr_sh[0];
         else if (kind == K_IDCODE || kind == K_USERCODE)
            tdo <= id_sh[0];
         else
            tdo <= bypass_bit;
      end
   end

   // =====================================================================
   // System clock side: mode and update toggle crossing
   bit_sync #(.WIDTH (3)) u_ctl_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({upd_tgl, highz_t, drive_cells_t}),
      .q     (ctl_sync)
   );

   // Update word is stable long before its toggle arrives here
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tgl_seen <= 1'b0;
         upd_copy <= '0;
      end
      else
      begin
         tgl_seen <= ctl_sync[2];
         if (ctl_sync[2] != tgl_seen)
            upd_copy <= bsr_upd;
      end
   end

   // =====================================================================
   // Pin drivers
   always_ff @(posedge clk)
   begin
      if (!rst_n || ctl_sync[1])
      begin
         out_pin    <= '0;
         out_pin_oe <= '0;
         bd_pin_out <= '0;
         bd_pin_oe  <= '0;
      end
      else if (ctl_sync[0])
      begin
         out_pin    <= upd_copy[NI +: NO];
         out_pin_oe <= '1;
         for (int i = 0; i < NB; i++)
         begin
            bd_pin_out[i] <= upd_copy[BD_BASE + CELLS_BIDIR*i + 1];
            bd_pin_oe[i]  <= upd_copy[BD_BASE + CELLS_BIDIR*i + 2];
         end
      end
      else
      begin
         out_pin    <= sys_out;
         out_pin_oe <= '1;
         bd_pin_out <= sys_bd_out;
         bd_pin_oe  <= sys_bd_oe;
      end
   end

endmodule : jtag_tap_boundary_scan

`default_nettype wire

// ===== core/jtag_tap_pkg.sv
// Constants shared by the test access port, its assertions and its bench
package jtag_tap_pkg;

   // =====================================================================
   // Instruction register
   localparam int          IR_W        = 6;
   localparam logic [5:0]  IR_EXTEST   = 6'h00;
   localparam logic [5:0]  IR_SAMPLE   = 6'h01;
   localparam logic [5:0]  IR_CLAMP    = 6'h02;
   localparam logic [5:0]  IR_HIGHZ    = 6'h05;
   localparam logic [5:0]  IR_IDCODE   = 6'h20;
   localparam logic [5:0]  IR_USERCODE = 6'h25;
   localparam logic [5:0]  IR_BYPASS   = 6'h3F;
   // Fixed pattern captured into the instruction shift stage
   localparam logic [5:0]  IR_CAPTURE  = 6'h01;

   // =====================================================================
   // Boundary scan chain layout
   localparam int BSR_LEN    = 161;
   localparam int NUM_IN     = 40;
   localparam int NUM_OUT    = 40;
   localparam int NUM_BIDIR  = 27;
   localparam int CELLS_BIDIR = 3;

   // =====================================================================
   // Identification word layout
   localparam int ID_W       = 32;
   localparam int ID_VER_LSB = 28;
   localparam int ID_FAM_LSB = 12;
   localparam int ID_MFR_LSB = 1;
   localparam logic       ID_LSB_ONE   = 1'b1;
   // Arbitrary neutral identity values
   localparam logic [3:0]  ID_VERSION   = 4'h3;
   localparam logic [3:0]  USER_VERSION = 4'h2;
   localparam logic [15:0] ID_FAMILY    = 16'h1234;
   localparam logic [15:0] ID_PART      = 16'h5678;
   localparam logic [10:0] ID_MFR       = 11'h2A5;

   // =====================================================================
   // Decoded instruction
   typedef enum logic [2:0] {
      K_EXTEST, K_SAMPLE, K_IDCODE, K_USERCODE, K_CLAMP, K_HIGHZ, K_BYPASS
   } instr_t;

endpackage : jtag_tap_pkg

// ===== core/bit_sync.sv
// Two-stage synchroniser for independent level signals
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   // =====================================================================
   // First stage is read only by the second
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : bit_sync

`default_nettype wire

// ===== tb/jtag_tap_asserts.sv
// Port-level assertions for the test access port
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_asserts
   import jtag_tap_pkg::*;
#(
   parameter int NO = NUM_OUT,
   parameter int NB = NUM_BIDIR
) (
   // Clocks and resets
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic          tck,
   input wire logic          trst_n,
   // Test access port
   input wire logic          tms,
   input wire logic          tdo,
   input wire logic          tdo_oe,
   // Pin enables
   input wire logic [NO-1:0] out_pin_oe,
   input wire logic [NB-1:0] bd_pin_oe
);

   // ====
   // Walks of the controller
   sequence s_enter;
      tms ##1 !tms ##1 !tms;
   endsequence
   sequence s_tlr_id;
      tms [*5] ##1 !tms ##1 s_enter;
   endsequence

   // ====
   // Serial side
   a_tlr_quiet: assert property (@(posedge tck) disable iff (!trst_n)
      tms [*5] |-> !tdo_oe) else $error("tdo driven after reset walk");
   a_oe_entry: assert property (@(posedge tck) disable iff (!trst_n)
      $rose(tdo_oe) |-> !$past(tms) && ($past(tms, 2) != $past(tms, 3)))
      else $error("tdo enabled outside shift entry");
   a_oe_exit: assert property (@(posedge tck) disable iff (!trst_n)
      $fell(tdo_oe) |-> $past(tms)) else $error("tdo released early");
   a_oe_hold: assert property (@(posedge tck) disable iff (!trst_n)
      tdo_oe && !tms |=> tdo_oe) else $error("shift left without tms");
   a_id_first: assert property (@(posedge tck) disable iff (!trst_n)
      s_tlr_id |=> tdo_oe && tdo) else $error("identity bit 0 not one");
   a_trst_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !trst_n |-> !tdo_oe && !tdo) else $error("tdo active in tap reset");

   // ====
   // Pin side
   a_oe_uniform: assert property (@(posedge clk) disable iff (!rst_n)
      out_pin_oe == '0 || out_pin_oe == '1) else $error("mixed output oe");
   a_highz_all: assert property (@(posedge clk) disable iff (!rst_n)
      out_pin_oe == '0 |-> bd_pin_oe == '0) else $error("bidir still driven");

endmodule : jtag_tap_asserts

bind jtag_tap_boundary_scan jtag_tap_asserts #(.NO(NO), .NB(NB)) i_asserts (
   .clk(clk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms),
   .tdo(tdo), .tdo_oe(tdo_oe), .out_pin_oe(out_pin_oe),
   .bd_pin_oe(bd_pin_oe));

`default_nettype wire

// ===== tb/tester.sv
// Behavioural board tester on the test access port
`timescale 1ns/1ps
`default_nettype none

module tester (
   // Test access port
   output var  logic tck,
   output var  logic trst_n,
   output var  logic tms,
   output var  logic tdi,
   input  wire logic tdo
);
   localparam time HALF = 32ns;

   initial
   begin
      tck = 1'b0;
      trst_n = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // ====
   // One period; tck idles low between frames
   task automatic step(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      #HALF tck = 1'b1;
      o = tdo;
      #HALF tck = 1'b0;
   endtask : step

   // Outside shift tdi toggles, never a stale level
   task automatic move(input logic m);
      logic o;
      step(m, ~tdi, o);
   endtask : move

   // Edges under reset clear the tck-side pin stages
   task automatic tap_reset();
      logic o;
      trst_n <= 1'b0;
      repeat (3) step(1'b1, 1'b0, o);
      trst_n <= 1'b1;
      #HALF;
      move(1'b0);
   endtask : tap_reset

   // From idle to idle through one register
   task automatic scan(input logic ir, input int n,
                       input logic [160:0] din, output logic [160:0] dout);
      logic o;
      dout = '0;
      move(1'b1);
      if (ir)
         move(1'b1);
      move(1'b0);
      move(1'b0);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      move(1'b1);
      move(1'b0);
   endtask : scan

endmodule : tester

`default_nettype wire

// ===== tb/jtag_tap_boundary_scan_bench.sv
// Self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_boundary_scan_bench
   import jtag_tap_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        tck;
   logic        trst_n;
   logic        tms;
   logic        tdi;
   logic        tdo;
   logic        tdo_oe;
   logic [39:0] in_pin;
   logic [39:0] out_pin;
   logic [39:0] out_pin_oe;
   logic [39:0] sys_out;
   logic [26:0] bd_pin_in;
   logic [26:0] bd_pin_out;
   logic [26:0] bd_pin_oe;
   logic [26:0] sys_bd_out;
   logic [26:0] sys_bd_oe;
   logic [160:0] rd;
   logic [160:0] pre;
   int          err_count = 0;
   int          compares = 0;

   tester i_tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
                    .tdo(tdo));
   jtag_tap_boundary_scan i_jtag_tap_boundary_scan (
      .clk(clk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .in_pin(in_pin),
      .out_pin(out_pin), .out_pin_oe(out_pin_oe), .bd_pin_in(bd_pin_in),
      .bd_pin_out(bd_pin_out), .bd_pin_oe(bd_pin_oe), .sys_out(sys_out),
      .sys_bd_out(sys_bd_out), .sys_bd_oe(sys_bd_oe));

   // ====
   // Shared helpers
   task automatic check(input logic [160:0] seen, input logic [160:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("errors %0d, compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic load_ir(input logic [5:0] code);
      i_tester.scan(1'b1, IR_W, code, rd);
      check(rd[5:0], 6'h01);
   endtask : load_ir

   function automatic logic [160:0] cap();
      logic [160:0] v;
      v = '0;
      v[39:0] = in_pin;
      v[79:40] = sys_out;
      for (int i = 0; i < NUM_BIDIR; i++)
      begin
         v[80 + 3*i] = bd_pin_in[i];
         v[81 + 3*i] = sys_bd_out[i];
         v[82 + 3*i] = sys_bd_oe[i];
      end
      return v;
   endfunction : cap

   // ====
   // Scenarios
   task automatic t_ident();
      i_tester.tap_reset();
      i_tester.scan(1'b0, 32, '0, rd);
      check(rd[31:0], {ID_VERSION, ID_FAMILY, ID_MFR, 1'b1});
      load_ir(IR_USERCODE);
      i_tester.scan(1'b0, 32, '0, rd);
      check(rd[31:0], {USER_VERSION, ID_PART, ID_MFR, 1'b1});
      load_ir(IR_BYPASS);
      repeat (5) i_tester.move(1'b1);
      i_tester.move(1'b0);
      i_tester.scan(1'b0, 32, '0, rd);
      check(rd[31:0], {ID_VERSION, ID_FAMILY, ID_MFR, 1'b1});
   endtask : t_ident

   task automatic t_bypass();
      logic [5:0] codes [3] = '{IR_BYPASS, 6'h03, 6'h2A};
      foreach (codes[k])
      begin
         load_ir(codes[k]);
         i_tester.scan(1'b0, 9, 9'h0B5, rd);
         check(rd[8:0], {8'hB5, 1'b0});
      end
      @(posedge clk);
      sys_out <= 40'h0F0F0F0F0F;
      repeat (3) @(posedge clk);
      check(out_pin, 40'h0F0F0F0F0F);
   endtask : t_bypass

   task automatic t_extest();
      logic [26:0] ev;
      logic [26:0] eo;
      pre = '0;
      pre[79:40] = 40'hC3A55A3C96;
      for (int i = 0; i < NUM_BIDIR; i++)
      begin
         pre[81 + 3*i] = i[0];
         pre[82 + 3*i] = i[1];
         ev[i] = i[0];
         eo[i] = i[1];
      end
      load_ir(IR_SAMPLE);
      i_tester.scan(1'b0, BSR_LEN, pre, rd);
      check(rd, cap());
      repeat (6) @(posedge clk);
      check(out_pin, sys_out);
      load_ir(IR_EXTEST);
      repeat (6) @(posedge clk);
      check(out_pin, pre[79:40]);
      check({bd_pin_oe, bd_pin_out}, {eo, ev});
      i_tester.scan(1'b0, BSR_LEN, pre, rd);
      check(rd, cap());
      load_ir(IR_CLAMP);
      @(posedge clk);
      sys_out <= ~sys_out;
      repeat (6) @(posedge clk);
      check(out_pin, pre[79:40]);
      i_tester.scan(1'b0, 3, 3'b011, rd);
      check(rd[2:0], 3'b110);
      load_ir(IR_HIGHZ);
      repeat (6) @(posedge clk);
      check({bd_pin_oe, out_pin_oe}, '0);
   endtask : t_extest

   // ====
   // Clock, reset, sequence and watchdog
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      rst_n = 1'b0;
      in_pin = 40'h123456789A;
      sys_out = 40'h6699AA5501;
      bd_pin_in = 27'h5A3C1E7;
      sys_bd_out = 27'h3C0F0F1;
      sys_bd_oe = 27'h6AAAAAA;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_ident();
      t_bypass();
      t_extest();
      end_sim();
   end

   // Whole run is near 41 us; far more means a hang
   initial
   begin
      #1ms;
      err_count++;
      end_sim();
   end

endmodule : jtag_tap_boundary_scan_bench

`default_nettype wire
